// *** hw/serial_status_defines.vh ***
// register map, field positions, reset values and timing counts of the serial status block
// assumes inclusion by bare name from the design files
`ifndef SERIAL_STATUS_DEFINES_VH
`define SERIAL_STATUS_DEFINES_VH
// byte offsets on the apb bus
`define OFF_CONTROL      12'h000
`define OFF_STATUS       12'h004
`define OFF_TX_HOLDING   12'h008
`define OFF_RX_HOLDING   12'h00c
`define OFF_TIMEOUT_CNT  12'h010
`define OFF_IRQ_STATUS   12'h014
`define OFF_IRQ_MASK     12'h018
// control register command bits
`define CTL_RX_ENABLE     0
`define CTL_RX_DISABLE    1
`define CTL_TX_ENABLE     2
`define CTL_TX_DISABLE    3
`define CTL_STATUS_CLEAR  4
`define CTL_BREAK_START   5
`define CTL_TIMEOUT_RST   6
// status word bit positions
`define ST_RX_AVAIL   0
`define ST_TX_FREE    1
`define ST_BREAK      2
`define ST_OVERRUN    5
`define ST_FRAME      6
`define ST_PARITY     7
`define ST_TIMEOUT    8
`define ST_WIDTH      9
// reset values
`define RST_TIMEOUT_CNT  16'h0000
`define RST_IRQ_MASK     9'h000
// one timeout tick is one bit period of the line
`define BIT_TIME_NS      8680
`define CLK_PERIOD_NS    20
`define BIT_TIME_CYC     ((`BIT_TIME_NS) / (`CLK_PERIOD_NS))
`endif

// *** hw/rx_timeout_timer.v ***
// receive timeout counter: counts idle bit periods after a restart command
// assumes restart and character pulses on the same clock as clk_sys
`timescale 1ns/100ps
`include "serial_status_defines.vh"
module rx_timeout_timer (
  // clock and reset
  input  wire        clk_sys,
  input  wire        resetn,
  // control
  input  wire [15:0] timeoutCount,
  input  wire        restartPulse,
  input  wire        charPulse,
  // result
  output reg         expiredPulse
);
  reg [12:0] tickCnt_q;
  reg [15:0] bitCnt_q;
  reg        armed_q;
  wire       tick;

  // reload cut to the prescaler width on purpose; a bit period fits in 13 bits
  localparam [31:0] TICK_RELOAD = `BIT_TIME_CYC - 1;

  assign tick = (tickCnt_q == 13'h0000);

  // prescaler gives one tick per bit period
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tickCnt_q <= 13'h0000;
    end else if (tick || restartPulse || charPulse) begin
      tickCnt_q <= TICK_RELOAD[12:0];
    end else begin
      tickCnt_q <= tickCnt_q - 13'h0001;
    end
  end

  // a zero count disables the timer so the flag can never rise
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bitCnt_q     <= 16'h0000;
      armed_q      <= 1'b0;
      expiredPulse <= 1'b0;
    end else begin
      expiredPulse <= 1'b0;
      if (restartPulse || charPulse) begin
        bitCnt_q <= timeoutCount;
        armed_q  <= (timeoutCount != 16'h0000);
      end else if (armed_q && tick) begin
        if (bitCnt_q <= 16'h0001) begin
          armed_q      <= 1'b0;
          expiredPulse <= 1'b1;
        end else begin
          bitCnt_q <= bitCnt_q - 16'h0001;
        end
      end
    end
  end
endmodule

// *** hw/serial_port_status_flags.v ***
// status flags of a serial port: error, timeout and holding register handshakes over apb
// assumes character engine event pulses on clk_sys; pins are not used by this block
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "serial_status_defines.vh"
// What this block does
// - timeout flag rises after count elapses; zero count reads 0
// - parity fault bit 7, sticky until status clear
// - stop bit low sets bit 6, sticky
// - overrun bit 5, sticky until status clear
// - break start and end set bit 2
// - status clear command clears four error flags
// - tx ready low on pending char, break, disabled
// - tx ready high on enable and empty holding
// - rx ready bit 0 until holding register read
// - rx ready low while disabled, restored on enable
// - timeout bit 8, cleared by restart command
// - holding write while tx busy is discarded
module serial_port_status_flags (
  // clock and reset
  input  wire        clk_sys,
  input  wire        resetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // receive engine events
  input  wire        rxCharDone,
  input  wire [7:0]  rxCharData,
  input  wire        rxParityBad,
  input  wire        rxStopLow,
  input  wire        rxBreakEdge,
  input  wire        rxActive,
  // transmit engine handshake
  input  wire        txShiftTake,
  output reg         txCharValid,
  output reg  [7:0]  txCharData,
  output reg         txBreakReq,
  input  wire        txBreakDone,
  // interrupt
  output reg         irq
);
  reg        rxEnable_q;
  reg        txEnable_q;
  reg        rxPending_q;
  reg        rxAvail_q;
  reg [7:0]  rxHold_q;
  reg        parity_q;
  reg        frame_q;
  reg        overrun_q;
  reg        brk_q;
  reg        timeout_q;
  reg [15:0] toCount_q;
  reg [8:0]  irqStat_q;
  reg [8:0]  irqMask_q;
  reg [8:0]  stPrev_q;
  reg [31:0] rdata_d;
  reg        mapped;
  wire       access;
  wire       wrEn;
  wire       rdEn;
  wire       ctlWr;
  wire       clrCmd;
  wire       toRestart;
  wire       txFree;
  wire       thrWr;
  wire       rhrRd;
  wire       toExpired;
  wire [8:0] statusWord;

  // access completes in the second cycle; pready is registered
  assign access    = psel && penable && !pready;
  assign wrEn      = access && pwrite;
  assign rdEn      = access && !pwrite;

  // register hits and the commands a control write carries
  assign ctlWr     = wrEn && (paddr == `OFF_CONTROL);
  assign clrCmd    = ctlWr && pwdata[`CTL_STATUS_CLEAR];
  assign toRestart = ctlWr && pwdata[`CTL_TIMEOUT_RST];
  assign thrWr     = wrEn && (paddr == `OFF_TX_HOLDING);
  assign rhrRd     = rdEn && (paddr == `OFF_RX_HOLDING);

  // tx ready: enabled, nothing held, no break queued
  assign txFree = txEnable_q && !txCharValid && !txBreakReq;

  // one word holds every flag; reading it has no side effect
  assign statusWord = {timeout_q,  // bit 8
                       parity_q,   // bit 7
                       frame_q,    // bit 6
                       overrun_q,  // bit 5
                       2'b00,      // bits 4 and 3 unused
                       brk_q,      // bit 2
                       txFree,     // bit 1
                       rxAvail_q};

  // bit-period timer, restarted by command and by every character
  rx_timeout_timer u_rx_timeout_timer (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .timeoutCount (toCount_q),
    .restartPulse (toRestart),
    .charPulse    (rxCharDone),
    .expiredPulse (toExpired)
  );

  // rx enable; a disable command wins over an enable in the same write
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxEnable_q <= 1'b0;
    end else if (ctlWr) begin
      if (pwdata[`CTL_RX_DISABLE])
        rxEnable_q <= 1'b0;
      else if (pwdata[`CTL_RX_ENABLE])
        rxEnable_q <= 1'b1;
    end
  end

  // tx enable; disable wins so a conflicting write leaves the line quiet
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txEnable_q <= 1'b0;
    end else if (ctlWr) begin
      if (pwdata[`CTL_TX_DISABLE])
        txEnable_q <= 1'b0;
      else if (pwdata[`CTL_TX_ENABLE])
        txEnable_q <= 1'b1;
    end
  end

  // receive holding data follows every accepted character
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      rxHold_q <= 8'h00;
    else if (rxCharDone && rxEnable_q)
      rxHold_q <= rxCharData;
  end

  // pending survives a disable so it can show again; a new char beats a read
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxPending_q <= 1'b0;
    end else if (rxCharDone && rxEnable_q) begin
      rxPending_q <= 1'b1;
    end else if (rhrRd) begin
      rxPending_q <= 1'b0;
    end else if (ctlWr && pwdata[`CTL_RX_DISABLE] && rxActive) begin
      rxPending_q <= 1'b1;
    end
  end

  // new character on an unread one is an overrun; set wins over clear
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      overrun_q <= 1'b0;
    else if (rxCharDone && rxEnable_q && rxPending_q && !rhrRd)
      overrun_q <= 1'b1;
    else if (clrCmd)
      overrun_q <= 1'b0;
  end

  // rx ready is masked by the enable
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      rxAvail_q <= 1'b0;
    else
      rxAvail_q <= rxEnable_q && rxPending_q && !(rhrRd && !rxCharDone);
  end

  // sticky receive errors, event beats the clear command
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      parity_q <= 1'b0;
      frame_q  <= 1'b0;
      brk_q    <= 1'b0;
    end else begin
      if (rxEnable_q && rxParityBad)
        parity_q <= 1'b1;
      else if (clrCmd)
        parity_q <= 1'b0;
      if (rxEnable_q && rxStopLow)
        frame_q <= 1'b1;
      else if (clrCmd)
        frame_q <= 1'b0;
      if (rxEnable_q && rxBreakEdge)
        brk_q <= 1'b1;
      else if (clrCmd)
        brk_q <= 1'b0;
    end
  end

  // timeout flag; zero count forces it low
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      timeout_q <= 1'b0;
    else if (toCount_q == 16'h0000)
      timeout_q <= 1'b0;
    else if (toExpired)
      timeout_q <= 1'b1;
    else if (toRestart)
      timeout_q <= 1'b0;
  end

  // transmit holding register; a write while busy is dropped with no error
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txCharValid <= 1'b0;
      txCharData  <= 8'h00;
    end else if (thrWr && txFree) begin
      txCharValid <= 1'b1;
      txCharData  <= pwdata[7:0];
    end else if (txShiftTake || !txEnable_q) begin
      txCharValid <= 1'b0;
    end
  end

  // break request holds tx ready low until the engine reports its end
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      txBreakReq <= 1'b0;
    else if (ctlWr && pwdata[`CTL_BREAK_START] && txEnable_q)
      txBreakReq <= 1'b1;
    else if (txBreakDone || !txEnable_q)
      txBreakReq <= 1'b0;
  end

  // timeout count in bit periods; zero parks the timer and the flag
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      toCount_q <= `RST_TIMEOUT_CNT;
    else if (wrEn && paddr == `OFF_TIMEOUT_CNT)
      toCount_q <= pwdata[15:0];
  end

  // interrupt mask shares the status word layout
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      irqMask_q <= `RST_IRQ_MASK;
    else if (wrEn && paddr == `OFF_IRQ_MASK)
      irqMask_q <= pwdata[`ST_WIDTH-1:0];
  end

  // interrupt status catches rising flags; a read clears, a new event wins
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stPrev_q  <= 9'h000;
      irqStat_q <= 9'h000;
    end else begin
      stPrev_q <= statusWord;
      if (rdEn && paddr == `OFF_IRQ_STATUS)
        irqStat_q <= statusWord & ~stPrev_q;
      else
        irqStat_q <= irqStat_q | (statusWord & ~stPrev_q);
    end
  end

  // level output from a flop, so it trails the interrupt status by one cycle and the status bits by two
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |(irqStat_q & irqMask_q);
  end

  // read mux; command and write-only registers read as zero
  always @* begin
    rdata_d = 32'h00000000;
    case (paddr)
      `OFF_STATUS:      rdata_d = {23'h0, statusWord};
      `OFF_RX_HOLDING:  rdata_d = {24'h000000, rxHold_q};
      `OFF_TIMEOUT_CNT: rdata_d = {16'h0000, toCount_q};
      `OFF_IRQ_STATUS:  rdata_d = {23'h0, irqStat_q};
      `OFF_IRQ_MASK:    rdata_d = {23'h0, irqMask_q};
      default:          rdata_d = 32'h00000000;
    endcase
  end

  // decode of mapped addresses for the error answer
  always @* begin
    mapped = 1'b0;
    case (paddr)
      `OFF_CONTROL, `OFF_STATUS, `OFF_TX_HOLDING, `OFF_RX_HOLDING,
      `OFF_TIMEOUT_CNT, `OFF_IRQ_STATUS, `OFF_IRQ_MASK: mapped = 1'b1;
      default:                                          mapped = 1'b0;
    endcase
  end

  // apb answer one cycle into the access phase; status write is an error
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= access;
      pslverr <= access && (!mapped || (pwrite && paddr == `OFF_STATUS));
    end
  end

  // read data only with a read answer, zero otherwise
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      prdata <= 32'h00000000;
    else
      prdata <= rdEn ? rdata_d : 32'h00000000;
  end
endmodule

// *** sim/serial_port_status_flags_assertions.sv ***
// port checker for the serial status block
// assumes one clock domain and apb requests held until pready
`timescale 1ns/100ps
`include "serial_status_defines.vh"
module serial_port_status_flags_chk (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // transmit handshake
  input wire logic        txShiftTake,
  input wire logic        txCharValid,
  input wire logic [7:0]  txCharData,
  input wire logic        txBreakReq,
  input wire logic        txBreakDone,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // taken write requests, seen at the edge that takes them
  wire take  = psel && penable && !pready && pwrite;
  wire ctlWr = take && paddr == `OFF_CONTROL;
  wire txWr  = take && paddr == `OFF_TX_HOLDING;
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
  property p_answer; psel && penable && !pready |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer one cycle after take");
  property p_no_spur; pready |-> $past(psel && penable); endproperty
  a_no_spur: assert property (p_no_spur) else $error("pready without request");
  property p_err_with; pslverr |-> pready; endproperty
  a_err_with: assert property (p_err_with) else $error("pslverr without pready");
  property p_ro_stat; pready && pwrite && paddr == `OFF_STATUS |-> pslverr; endproperty
  a_ro_stat: assert property (p_ro_stat) else $error("status write accepted");
  property p_wr_zero; pready && pwrite |-> prdata == 32'h0; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("read data on a write");
  // a held char can only change once the shifter took it
  property p_hold; txCharValid && !txShiftTake |=> $stable(txCharData) || !txCharValid; endproperty
  a_hold: assert property (p_hold) else $error("held char overwritten");
  property p_tx_rise; $rose(txCharValid) |-> $past(txWr) || $past(txWr, 2); endproperty
  a_tx_rise: assert property (p_tx_rise) else $error("char held without write");
  property p_tx_fall; $fell(txCharValid) |-> $past(txShiftTake) || $past(ctlWr) || $past(ctlWr, 2);
  endproperty
  a_tx_fall: assert property (p_tx_fall) else $error("held char lost");
  property p_brk; $fell(txBreakReq) |-> $past(txBreakDone) || $past(ctlWr) || $past(ctlWr, 2);
  endproperty
  a_brk: assert property (p_brk) else $error("break request dropped early");
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
  c_brk: cover property ($fell(txBreakReq));
endmodule

// *** sim/serial_engine_model.sv ***
// transmit engine stand-in: takes held chars and ends breaks
// assumes level requests from the status block on clk_sys
`timescale 1ns/100ps
module serial_engine_model (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // pace: slow mode leaves the holding register busy longer
  input  wire logic slowMode,
  // transmit handshake
  input  wire logic txCharValid,
  input  wire logic txBreakReq,
  output logic      txShiftTake,
  output logic      txBreakDone
);
  logic [6:0] waitCnt_q;
  // char goes first; restart after a pulse so one request gives one pulse
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      waitCnt_q <= 7'h00;
      txShiftTake <= 1'b0;
      txBreakDone <= 1'b0;
    end else begin
      txShiftTake <= 1'b0;
      txBreakDone <= 1'b0;
      if (!(txCharValid || txBreakReq) || txShiftTake || txBreakDone) begin
        waitCnt_q <= 7'h00;
      end else if (waitCnt_q < (slowMode ? 7'h3c : 7'h02)) begin
        waitCnt_q <= waitCnt_q + 7'h01;
      end else begin
        txShiftTake <= txCharValid;
        txBreakDone <= !txCharValid;
        waitCnt_q <= 7'h00;
      end
    end
  end
endmodule

// *** sim/serial_port_status_flags_bench.sv ***
// self-checking bench of the serial status block
// assumes the engine model on the transmit side; rx events come from here
`timescale 1ns/100ps
`include "serial_status_defines.vh"
module serial_port_status_flags_bench;
  logic        clk_sys = 0, resetn = 0, slowMode = 0, er;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic        rxCharDone = 0, rxParityBad = 0, rxStopLow = 0, rxBreakEdge = 0, rxActive = 0;
  logic [7:0]  rxCharData = 8'h00;
  wire  [31:0] prdata;
  wire  [7:0]  txCharData;
  wire         pready, pslverr, txShiftTake, txCharValid, txBreakReq, txBreakDone, irq;
  int          fail_count = 0, checked = 0;
  always #10 clk_sys = ~clk_sys;
  serial_port_status_flags u_serial_port_status_flags (.clk_sys(clk_sys), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxCharDone(rxCharDone),
    .rxCharData(rxCharData), .rxParityBad(rxParityBad), .rxStopLow(rxStopLow),
    .rxBreakEdge(rxBreakEdge), .rxActive(rxActive), .txShiftTake(txShiftTake),
    .txCharValid(txCharValid), .txCharData(txCharData), .txBreakReq(txBreakReq),
    .txBreakDone(txBreakDone), .irq(irq));
  serial_engine_model u_serial_engine_model (.clk_sys(clk_sys), .resetn(resetn),
    .slowMode(slowMode), .txCharValid(txCharValid), .txBreakReq(txBreakReq),
    .txShiftTake(txShiftTake), .txBreakDone(txBreakDone));
  task wrap_up;
    if (fail_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task apb(input w, input [11:0] a, input [31:0] d);
    int n;
    @(posedge clk_sys); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys); penable <= 1;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata; er = pslverr; psel <= 0; penable <= 0;
    if (pready !== 1'b1) begin fail_count++; wrap_up; end
  endtask
  task stat(input [31:0] e); apb(0, `OFF_STATUS, 0); chk(rd, e); endtask
  // one-cycle receive event pulses
  task ev(input [3:0] m, input [7:0] d);
    @(posedge clk_sys); {rxBreakEdge, rxStopLow, rxParityBad, rxCharDone} <= m; rxCharData <= d;
    @(posedge clk_sys); {rxBreakEdge, rxStopLow, rxParityBad, rxCharDone} <= 4'h0;
  endtask
  // bounded poll for a free holding register
  task waitFree;
    int n;
    n = 0;
    do begin apb(0, `OFF_STATUS, 0); n++; end while (rd[1] !== 1'b1 && n < 40);
    chk(rd, 32'h2);
    if (rd[1] !== 1'b1) wrap_up;
  endtask
  task t_reset;
    stat(32'h0);
    apb(0, `OFF_IRQ_MASK, 0); chk(rd, 32'h0);
    apb(0, `OFF_TIMEOUT_CNT, 0); chk(rd, 32'h0);
  endtask
  task t_errors;
    apb(1, `OFF_CONTROL, 32'h1);
    ev(4'b0011, 8'h11); ev(4'b0101, 8'h22); ev(4'b1000, 8'h00);
    stat(32'he5);
    stat(32'he5);
    apb(0, `OFF_RX_HOLDING, 0); stat(32'he4);
    apb(1, `OFF_CONTROL, 32'h10); stat(32'h0);
    ev(4'b1000, 8'h00); stat(32'h4);
    apb(1, `OFF_CONTROL, 32'h10); stat(32'h0);
  endtask
  task t_rxdis;
    rxActive <= 1; apb(1, `OFF_CONTROL, 32'h2); rxActive <= 0;
    stat(32'h0);
    apb(1, `OFF_CONTROL, 32'h1); stat(32'h1);
    apb(0, `OFF_RX_HOLDING, 0); stat(32'h0);
  endtask
  task t_tx;
    slowMode <= 1; apb(1, `OFF_CONTROL, 32'h4); stat(32'h2);
    apb(1, `OFF_TX_HOLDING, 32'ha5); stat(32'h0);
    apb(1, `OFF_TX_HOLDING, 32'h3c); chk(txCharData, 32'ha5);
    waitFree;
    apb(1, `OFF_CONTROL, 32'h20); stat(32'h0);
    chk(txBreakReq, 32'h1);
    waitFree;
    slowMode <= 0; apb(1, `OFF_TX_HOLDING, 32'h5a); waitFree;
    apb(1, `OFF_CONTROL, 32'h8); stat(32'h0);
    apb(1, `OFF_TX_HOLDING, 32'h77); chk(txCharValid, 32'h0);
  endtask
  // count 0 never expires; count 2 expires within three bit periods
  task t_timeout;
    apb(0, `OFF_IRQ_STATUS, 0); apb(1, `OFF_IRQ_MASK, 32'h100); chk(irq, 32'h0);
    for (int c = 0; c <= 2; c += 2) begin
      apb(1, `OFF_TIMEOUT_CNT, c); apb(1, `OFF_CONTROL, 32'h40);
      repeat (3 * `BIT_TIME_CYC) @(posedge clk_sys);
      stat(c ? 32'h100 : 32'h0);
    end
    chk(irq, 32'h1);
    apb(0, `OFF_IRQ_STATUS, 0); chk(rd, 32'h100);
    repeat (3) @(posedge clk_sys); chk(irq, 32'h0);
    apb(1, `OFF_CONTROL, 32'h40); stat(32'h0);
  endtask
  task t_map;
    apb(0, 12'h01c, 0); chk(er, 32'h1);
    apb(1, `OFF_STATUS, 32'h1ff); chk(er, 32'h1);
    stat(32'h0);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1;
    t_reset; t_errors; t_rxdis; t_tx; t_timeout; t_map;
    wrap_up;
  end
endmodule
bind serial_port_status_flags serial_port_status_flags_chk u_chk (.clk_sys(clk_sys), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .txShiftTake(txShiftTake), .txCharValid(txCharValid),
  .txCharData(txCharData), .txBreakReq(txBreakReq), .txBreakDone(txBreakDone), .irq(irq));
